// ===== verif/fcs_osc_model.sv
// oscillator sources and pll seen by the failsafe clock monitor
// assumes clk_i is the 40 MHz system clock; edges arrive as one-cycle pulses
`timescale 1ns/1ps

module fcs_osc_model
  import fcs_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       osc_run_i,
  input  wire logic       lock_ok_i,
  input  wire logic       low_power_rc_osc_en_i,
  input  wire logic       pll_used_i,
  input  wire logic       crystal_i,
  output fcs_osc_status_t osc_o
);
  logic [1:0] osc_div;
  logic [2:0] rc_div;
  logic [2:0] start_cnt;
  logic       osc_edge;

  assign osc_edge = osc_run_i && osc_div[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !osc_run_i)
      osc_div <= 2'h0;
    else
      osc_div <= osc_div + 2'h1;
  end

  // low-power rc runs only while the monitor enables it
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !low_power_rc_osc_en_i)
      rc_div <= 3'h0;
    else
      rc_div <= rc_div + 3'h1;
  end

  // start-up timer: four oscillator edges after the oscillator starts
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !osc_run_i)
      start_cnt <= 3'h0;
    else if (osc_edge && start_cnt != 3'h4)
      start_cnt <= start_cnt + 3'h1;
  end

  assign osc_o = '{osc_edge, low_power_rc_osc_en_i && (rc_div == 3'h7), start_cnt == 3'h4,
                   lock_ok_i && (start_cnt == 3'h4), pll_used_i, crystal_i};
endmodule

// ===== verif/test_failsafe_clock_switch_monitor.sv
// self-checking bench for the failsafe clock switch monitor
// assumes the oscillator model and a classic wishbone master driven here
`timescale 1ns/1ps

module test_failsafe_clock_switch_monitor;
  import fcs_pkg::*;
  localparam int PU_CYC = 8;

  logic            clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic            por_i = 1'b1;
  logic            brownout_i = 1'b0;
  logic            sleep_i = 1'b0;
  logic            wdt_en = 1'b0;
  logic            osc_run = 1'b0;
  logic            lock_ok = 1'b1;
  logic            pll_used = 1'b0;
  logic            ce = 1'b1;
  logic            xtal = 1'b1;
  fcs_config_t     cfg = '{2'b01, 2'h1, 4'h5, 1'b1};
  logic            wb_cyc = 1'b0;
  logic            wb_stb = 1'b0;
  logic            wb_we = 1'b0;
  logic [3:0]      wb_adr = 4'h0;
  logic [3:0]      wb_sel = 4'h0;
  logic [31:0]     wb_wdat = 32'h0;
  logic [31:0]     wb_dat_o;
  logic            wb_ack_o;
  logic [1:0]      osc_group_o;
  logic [3:0]      primary_select_o;
  logic            low_rc_enable_o;
  logic            watchdog_clk_sel_o;
  logic            core_reset_o;
  logic            clock_hold_o;
  logic            fail_trap_o;
  fcs_osc_status_t osc;
  logic [31:0]     q;
  int              n;
  int              bad_count = 0;
  int              check_count = 0;

  always #12.5 clk_i = ~clk_i;

  fcs_osc_model u_osc (.clk_i(clk_i), .rst_i(rst_i), .osc_run_i(osc_run), .lock_ok_i(lock_ok),
    .low_power_rc_osc_en_i(low_rc_enable_o), .pll_used_i(pll_used), .crystal_i(xtal), .osc_o(osc));

  fcs_monitor #(.POWER_UP_CYC(PU_CYC), .MONITOR_CYC(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce), .por_i(por_i), .brownout_i(brownout_i), .sleep_i(sleep_i),
    .watchdog_soft_enable_i(wdt_en), .osc_i(osc), .cfg_i(cfg), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .osc_group_o(osc_group_o),
    .primary_select_o(primary_select_o), .low_rc_enable_o(low_rc_enable_o),
    .watchdog_clk_sel_o(watchdog_clk_sel_o), .core_reset_o(core_reset_o),
    .clock_hold_o(clock_hold_o), .fail_trap_o(fail_trap_o));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic we, input logic [3:0] adr, input logic [3:0] sel, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_sel  <= sel;
    wb_wdat <= d;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    check("bus_ack", 32'(k < 20), 32'h1);
    if (k >= 20)
      summarize();
  endtask

  task automatic unlock(input logic hi);
    if (hi)
    begin
      bus(1'b1, ADDR_CTRL, 4'h2, {16'h0, KEY_HI_A, 8'h0});
      bus(1'b1, ADDR_CTRL, 4'h2, {16'h0, KEY_HI_B, 8'h0});
    end
    else
    begin
      bus(1'b1, ADDR_CTRL, 4'h1, {24'h0, KEY_LO_A});
      bus(1'b1, ADDR_CTRL, 4'h1, {24'h0, KEY_LO_B});
    end
  endtask

  task automatic do_reset(input fcs_config_t c, input logic bor = 1'b0);
    int hold;
    hold = 0;
    cfg        <= c;
    rst_i      <= !bor;
    por_i      <= !bor;
    brownout_i <= bor;
    repeat (6) @(posedge clk_i);
    check("reset_core", core_reset_o, 32'h1);
    rst_i      <= 1'b0;
    por_i      <= 1'b0;
    brownout_i <= 1'b0;
    n = 0;
    while ((core_reset_o !== 1'b0 || clock_hold_o !== 1'b0) && n < 300 && osc_run)
    begin
      @(posedge clk_i);
      n++;
      if (core_reset_o === 1'b1)
        hold++;
    end
    if (osc_run && c.power_up_timer_enable)
      check("power_up_timer_hold", 32'(hold >= PU_CYC && n < 300), 32'h1);
    else if (osc_run)
      check("fast_exit", 32'(hold <= 2 && n < 300), 32'h1);
  endtask

  task automatic wait_trap(input int lim);
    n = 0;
    while (fail_trap_o !== 1'b1 && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_and_map();
    osc_run <= 1'b1;
    do_reset('{2'b01, 2'h1, 4'h5, 1'b1});
    bus(1'b0, ADDR_CTRL, 4'hf, 32'h0);
    check("ctrl_reset", q, 32'h0000_1120);
    check("group_out", osc_group_o, 32'h1);
    check("prim_sel", primary_select_o, 32'h5);
    bus(1'b0, ADDR_CONFIG, 4'hf, 32'h0);
    check("cfg_read", q, {23'h0, cfg});
    bus(1'b0, 4'hc, 4'hf, 32'h0);
    check("unmapped", q, 32'h0);
    lock_ok <= 1'b0;
    bus(1'b0, ADDR_CTRL, 4'hf, 32'h0);
    check("lock_low", q, 32'h0000_1100);
  endtask

  task automatic t_switch();
    bus(1'b1, ADDR_CTRL, 4'h1, 32'h1);
    unlock(1'b1);
    bus(1'b1, ADDR_CTRL, 4'h2, 32'h0000_3000);
    bus(1'b1, ADDR_CTRL, 4'h2, 32'h0000_0100);
    bus(1'b0, ADDR_CTRL, 4'hf, 32'h0);
    check("next_write", q, 32'h0000_1000);
    bus(1'b1, ADDR_CTRL, 4'h1, {24'h0, KEY_LO_A});
    bus(1'b1, ADDR_RESET_CAUSE, 4'h1, 32'h0);
    bus(1'b1, ADDR_CTRL, 4'h1, {24'h0, KEY_LO_B});
    bus(1'b1, ADDR_CTRL, 4'h1, 32'h1);
    bus(1'b0, ADDR_CTRL, 4'hf, 32'h0);
    check("disarmed", q, 32'h0000_1000);
    unlock(1'b0);
    bus(1'b1, ADDR_CTRL, 4'h1, 32'h1);
    bus(1'b0, ADDR_CTRL, 4'hf, 32'h0);
    check("switched", q, 32'h0);
    check("group_sw", osc_group_o, 32'h0);
  endtask

  task automatic t_brownout();
    sleep_i <= 1'b1;
    do_reset(cfg, 1'b1);
    sleep_i <= 1'b0;
    bus(1'b0, ADDR_RESET_CAUSE, 4'hf, 32'h0);
    check("bor_flag", q & 32'h2, 32'h2);
    bus(1'b0, ADDR_CTRL, 4'hf, 32'h0);
    check("bor_groups", q & 32'h3300, 32'h1100);
    bus(1'b1, ADDR_RESET_CAUSE, 4'h1, 32'h0);
    bus(1'b0, ADDR_RESET_CAUSE, 4'hf, 32'h0);
    check("bor_clear", q & 32'h2, 32'h0);
  endtask

  task automatic t_fail();
    lock_ok <= 1'b1;
    do_reset('{2'b00, 2'h0, 4'h3, 1'b1});
    check("low_power_rc_osc_on", low_rc_enable_o, 32'h1);
    sleep_i <= 1'b1;
    @(posedge clk_i);
    @(posedge clk_i);
    check("low_power_rc_osc_sleep", low_rc_enable_o, 32'h0);
    sleep_i <= 1'b0;
    osc_run <= 1'b0;
    ce      <= 1'b0;
    repeat (60) @(posedge clk_i);
    check("ce_freeze", {fail_trap_o, osc_group_o}, 32'h0);
    ce      <= 1'b1;
    wait_trap(300);
    check("trap_seen", 32'(n < 300), 32'h1);
    @(posedge clk_i);
    check("trap_pulse", fail_trap_o, 32'h0);
    check("fail_group", osc_group_o, 32'h2);
    check("wdt_clk", watchdog_clk_sel_o, 32'h1);
    bus(1'b0, ADDR_CTRL, 4'hf, 32'h0);
    check("fail_ctrl", q & 32'h3009, 32'h2008);
  endtask

  task automatic t_slow_start();
    pll_used <= 1'b1;
    lock_ok  <= 1'b0;
    osc_run  <= 1'b1;
    do_reset('{2'b00, 2'h1, 4'h3, 1'b1});
    wait_trap(300);
    check("slow_trap", 32'(n < 300), 32'h1);
    bus(1'b0, ADDR_CTRL, 4'hf, 32'h0);
    check("slow_ctrl", q & 32'h3008, 32'h2008);
    pll_used <= 1'b0;
    lock_ok  <= 1'b1;
  endtask

  task automatic t_disabled();
    osc_run <= 1'b0;
    do_reset('{2'b10, 2'h1, 4'h7, 1'b1});
    repeat (40) @(posedge clk_i);
    check("frozen", clock_hold_o, 32'h1);
    wait_trap(200);
    check("no_trap", n, 32'd200);
    osc_run <= 1'b1;
    xtal    <= 1'b0;
    do_reset('{2'b10, 2'h1, 4'h7, 1'b0});
    unlock(1'b1);
    bus(1'b1, ADDR_CTRL, 4'h2, 32'h0);
    unlock(1'b0);
    bus(1'b1, ADDR_CTRL, 4'h1, 32'h1);
    repeat (2) @(posedge clk_i);
    check("dis_group", osc_group_o, 32'h1);
    check("dis_prim", primary_select_o, 32'h7);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    t_reset_and_map();
    t_switch();
    t_brownout();
    t_fail();
    t_slow_start();
    t_disabled();
    summarize();
  end

  initial
  begin
    #2_000_000;
    bad_count++;
    summarize();
  end
endmodule

// ===== verilog/fcs_monitor.sv
// failsafe clock supervision, switch control and power-up sequencing
// assumes oscillator status pulses are synchronous to clk_i
//
// Function
// RL1 - with monitoring enabled, low-power rc runs always except in sleep
// RL2 - on oscillator failure raise trap and switch system clock to fast rc
// RL3 - failure switch loads current group with fast rc, sets fail, clears request
// RL4 - clock failure leaves the watchdog running from low-power rc
// RL5 - power-up timer expiring before oscillator starts raises trap, selects fast rc
// RL6 - after timers, no oscillation, start-up timer running or pll unlocked is failure
// RL7 - switching only among four groups; primary choice fixed by primary select
// RL8 - current group read-only; software writes target into next group
// RL9 - power-on and brown-out reset load current and next from start-up group
// RL10 - read-only pll lock status at control bit 5
// RL11 - request rises when a switch starts; clearing it aborts the switch
// RL12 - config 1x disables both switching and failure monitoring
// RL13 - switching disabled: configuration drives selection, current group only reports
// RL14 - software should not switch below 100 khz while monitoring
// RL15 - low byte writable one cycle after keys 0x46 then 0x57
// RL16 - high byte writable one cycle after keys 0x78 then 0x9a
// RL17 - monitoring and power-up timer off: leave reset at once; with a crystal the code still waits MONITOR_CYC in reset
// RL18 - monitoring off and no clock: hold core at reset vector
// RL19 - brown-out: hold clock until start-up timer and pll lock
// RL20 - apply power-up delay; crystal with zero delay adds 100 us monitor delay
// RL21 - brown-out sets reset cause bit 1
// RL22 - brown-out detection keeps working in sleep and idle
// RL23 - failure when no oscillator edge within a low-power rc window
`timescale 1ns/1ps

module fcs_monitor
  import fcs_pkg::*;
#(
  parameter int POWER_UP_CYC = 65536,
  parameter int MONITOR_CYC  = MONITOR_DELAY_CYC
)(
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            ce_i,
  input  wire logic            por_i,
  input  wire logic            brownout_i,
  input  wire logic            sleep_i,
  input  wire logic            watchdog_soft_enable_i,
  input  wire fcs_osc_status_t osc_i,
  input  wire fcs_config_t     cfg_i,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [3:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic [31:0]          wb_dat_o,
  output logic                 wb_ack_o,
  output logic [1:0]           osc_group_o,
  output logic [3:0]           primary_select_o,
  output logic                 low_rc_enable_o,
  output logic                 watchdog_clk_sel_o,
  output logic                 core_reset_o,
  output logic                 clock_hold_o,
  output logic                 fail_trap_o
);

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  logic monitor_on;
  logic switch_on;
  assign switch_on  = ~cfg_i.monitor_switch_config[1];                  // RL12
  assign monitor_on = ~cfg_i.monitor_switch_config[1] & ~cfg_i.monitor_switch_config[0]; // RL12

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [1:0] cur_grp;
  logic [1:0] next_grp;
  logic       fail_flag;
  logic       req;
  logic       brownout_flag;
  logic       lo_armed;
  logic       lo_open;
  logic       hi_armed;
  logic       hi_open;
  logic       fail_evt;
  logic       switch_done;
  fcs_state_t state;
  logic [16:0] pu_cnt;
  logic [2:0] win_cnt;
  logic        osc_seen;

  logic wr;
  logic wr_ctrl_lo;
  logic wr_ctrl_hi;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign wr_ctrl_lo = wr & (wb_adr_i == ADDR_CTRL) & wb_sel_i[0];
  assign wr_ctrl_hi = wr & (wb_adr_i == ADDR_CTRL) & wb_sel_i[1];

  function automatic logic [1:0] reset_group(input fcs_config_t c);
    reset_group = c.startup_osc_group;
  endfunction

  // ----------------------------------------------------------------
  // bus slave: one-cycle answer, ack drops the next cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else if (ce_i)
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0;
    else if (ce_i && wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o)
    begin
      case (wb_adr_i)
        ADDR_CTRL:
        begin
          wb_dat_o <= 32'h0;
          wb_dat_o[CUR_GRP_LSB +: 2]  <= cur_grp;
          wb_dat_o[NEXT_GRP_LSB +: 2] <= next_grp;
          wb_dat_o[LOCK_BIT]          <= osc_i.pll_locked;      // RL10
          wb_dat_o[FAIL_BIT]          <= fail_flag;
          wb_dat_o[REQ_BIT]           <= req;
        end
        ADDR_RESET_CAUSE:
        begin
          wb_dat_o               <= 32'h0;
          wb_dat_o[BROWNOUT_BIT] <= brownout_flag;
        end
        ADDR_CONFIG:
          wb_dat_o <= {23'h0, cfg_i};
        default:
          wb_dat_o <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // unlock sequences: a key pair opens its byte for one write cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lo_armed <= 1'b0;
      lo_open  <= 1'b0;
    end
    else if (ce_i && wr)
    begin
      lo_armed <= wr_ctrl_lo && !lo_open && wb_dat_i[7:0] == KEY_LO_A;           // RL15
      lo_open  <= wr_ctrl_lo && lo_armed && wb_dat_i[7:0] == KEY_LO_B;           // RL15
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hi_armed <= 1'b0;
      hi_open  <= 1'b0;
    end
    else if (ce_i && wr)
    begin
      hi_armed <= wr_ctrl_hi && !hi_open && wb_dat_i[15:8] == KEY_HI_A;          // RL16
      hi_open  <= wr_ctrl_hi && hi_armed && wb_dat_i[15:8] == KEY_HI_B;          // RL16
    end
  end

  // ----------------------------------------------------------------
  // switch request and next group
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || por_i || brownout_i)
      next_grp <= 2'h0;
    else if (ce_i)
    begin
      if (state == FCS_ST_HOLD)
        next_grp <= reset_group(cfg_i);                                         // RL9
      else if (wr_ctrl_hi && hi_open)
        next_grp <= wb_dat_i[NEXT_GRP_LSB +: 2];                                // RL8
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || por_i || brownout_i)
      req <= 1'b0;
    else if (ce_i)
    begin
      if (fail_evt || switch_done)
        req <= 1'b0;                                                            // RL3
      else if (wr_ctrl_lo && lo_open && switch_on)
        req <= wb_dat_i[REQ_BIT];                                               // RL11
    end
  end

  assign switch_done = req && switch_on && state == FCS_ST_RUN;

  // ----------------------------------------------------------------
  // current group and fail flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || por_i || brownout_i)
      cur_grp <= 2'h0;
    else if (ce_i)
    begin
      if (!switch_on || state == FCS_ST_HOLD)
        cur_grp <= reset_group(cfg_i);                                          // RL9 RL13
      else if (fail_evt)
        cur_grp <= FCS_GRP_FAST_RC;                                             // RL3 RL5
      else if (switch_done)
        cur_grp <= next_grp;                                                    // RL7
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || por_i)
      fail_flag <= 1'b0;
    else if (ce_i && fail_evt)
      fail_flag <= 1'b1;                                                        // RL3
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || por_i)
      brownout_flag <= 1'b0;
    else if (ce_i)
    begin
      if (brownout_i)
        brownout_flag <= 1'b1;                                                  // RL21 RL22
      else if (wr && wb_adr_i == ADDR_RESET_CAUSE && wb_sel_i[0] && !wb_dat_i[BROWNOUT_BIT])
        brownout_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // power-up sequencer
  // ----------------------------------------------------------------
  logic clk_ready;
  logic pu_expired;
  assign clk_ready  = osc_seen && (osc_i.ost_done || !osc_i.crystal) &&
                      (osc_i.pll_locked || !osc_i.pll_used);                    // RL19
  assign pu_expired = pu_cnt == 17'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || por_i || brownout_i)
    begin
      state  <= FCS_ST_HOLD;
      pu_cnt <= 17'h0;
    end
    else if (ce_i)
    begin
      case (state)
        FCS_ST_HOLD:
        begin
          state <= FCS_ST_WAITPU;
          if (cfg_i.power_up_timer_enable)
            pu_cnt <= 17'(POWER_UP_CYC);                                        // RL20
          else if (osc_i.crystal)
            pu_cnt <= 17'(MONITOR_CYC);                                         // RL20
          else
            pu_cnt <= 17'h0;                                                    // RL17
        end
        FCS_ST_WAITPU:
          if (pu_expired)
            state <= FCS_ST_WAITCK;
          else
            pu_cnt <= pu_cnt - 17'h1;
        FCS_ST_WAITCK:
          if (clk_ready)
            state <= FCS_ST_RUN;
          else if (monitor_on)
            state <= FCS_ST_FAIL;                                               // RL5 RL6
        FCS_ST_RUN:
          if (fail_evt)
            state <= FCS_ST_FAIL;
        FCS_ST_FAIL:
          state <= FCS_ST_RUN;
        default:
          state <= FCS_ST_HOLD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // edge window timed by low-power rc
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || por_i || brownout_i)
    begin
      win_cnt  <= 3'h0;
      osc_seen <= 1'b0;
    end
    else if (ce_i)
    begin
      if (osc_i.osc_edge)
      begin
        win_cnt  <= 3'h0;
        osc_seen <= 1'b1;
      end
      else if (osc_i.low_power_rc_osc_edge)
      begin
        if (win_cnt == 3'(WINDOW_RC_EDGES - 1))
          osc_seen <= 1'b0;                                                     // RL23
        else
          win_cnt <= win_cnt + 3'h1;
      end
    end
  end

  // fast rc never needs the monitor; it is the fallback itself
  assign fail_evt = monitor_on && cur_grp != FCS_GRP_FAST_RC &&
                    ((state == FCS_ST_WAITCK && !clk_ready) ||
                     (state == FCS_ST_RUN && !osc_seen));                       // RL2 RL6 RL23

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fail_trap_o <= 1'b0;
    else if (ce_i)
      fail_trap_o <= fail_evt;                                                  // RL2
  end

  assign osc_group_o        = cur_grp;
  assign primary_select_o   = cfg_i.primary_osc_select;                          // RL7
  assign low_rc_enable_o    = monitor_on ? !sleep_i : watchdog_soft_enable_i;    // RL1
  assign watchdog_clk_sel_o = 1'b1;                                              // RL4
  assign core_reset_o       = state == FCS_ST_HOLD || state == FCS_ST_WAITPU;    // RL18
  assign clock_hold_o       = state == FCS_ST_WAITCK && !clk_ready;              // RL18 RL19

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  fail_group_a: assert property (@(posedge clk_i) disable iff (rst_i || por_i || brownout_i)
    ce_i && fail_evt && switch_on |=> cur_grp == FCS_GRP_FAST_RC && fail_flag && !req)
    else $error("fail switch did not load fast rc"); // RL3
  fail_trap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && fail_evt |=> fail_trap_o)
    else $error("trap missing after failure"); // RL2
  lowrc_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    monitor_on && !sleep_i |-> low_rc_enable_o)
    else $error("low rc stopped while monitoring"); // RL1
  wdog_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fail_trap_o |-> watchdog_clk_sel_o && low_rc_enable_o == (monitor_on ? !sleep_i : watchdog_soft_enable_i))
    else $error("watchdog clock disturbed"); // RL4
  no_monitor_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_i.monitor_switch_config[1] |-> !fail_evt && !fail_trap_o)
    else $error("monitor active when disabled"); // RL12
  report_sel_a: assert property (@(posedge clk_i) disable iff (rst_i || por_i || brownout_i)
    ce_i && !switch_on && !(rst_i || por_i || brownout_i) |=> cur_grp == $past(cfg_i.startup_osc_group))
    else $error("current group not tracking configuration"); // RL13
  lo_unlock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && lo_open && wr |=> !lo_open)
    else $error("low byte stayed open"); // RL15
  hi_unlock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr_ctrl_hi && !hi_armed |=> !hi_open)
    else $error("high byte opened without first key"); // RL16
  bo_flag_a: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    ce_i && brownout_i |=> brownout_flag)
    else $error("brownout flag not set"); // RL21
  hold_core_a: assert property (@(posedge clk_i) disable iff (rst_i || por_i || brownout_i)
    state == FCS_ST_WAITPU |-> core_reset_o)
    else $error("core released early"); // RL20

  fail_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) fail_trap_o);
  switch_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) switch_done);
  unlock_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) hi_open || lo_open);
  run_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) state == FCS_ST_RUN);

endmodule

// ===== verilog/fcs_pkg.sv
// package for the failsafe clock switch monitor
// assumes a single 40 MHz system clock domain
package fcs_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets on a 32-bit wishbone bus)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_RESET_CAUSE = 4'h4;
  localparam logic [3:0] ADDR_CONFIG    = 4'h8;

  // clock_switch_control fields
  localparam int CUR_GRP_LSB  = 12;
  localparam int NEXT_GRP_LSB = 8;
  localparam int LOCK_BIT     = 5;
  localparam int FAIL_BIT     = 3;
  localparam int REQ_BIT      = 0;
  // reset_cause_register field
  localparam int BROWNOUT_BIT = 1;

  // unlock keys
  localparam logic [7:0] KEY_LO_A = 8'h46;
  localparam logic [7:0] KEY_LO_B = 8'h57;
  localparam logic [7:0] KEY_HI_A = 8'h78;
  localparam logic [7:0] KEY_HI_B = 8'h9a;

  // oscillator groups
  typedef enum logic [1:0] {
    FCS_GRP_PRIMARY   = 2'h0,
    FCS_GRP_SECONDARY = 2'h1,
    FCS_GRP_FAST_RC   = 2'h2,
    FCS_GRP_LOW_RC    = 2'h3
  } fcs_grp_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ             = 40;
  localparam int MONITOR_DELAY_US    = 100;
  localparam int MONITOR_DELAY_CYC   = MONITOR_DELAY_US * CLK_MHZ;
  // failure window in low-power rc edges
  localparam int WINDOW_RC_EDGES     = 4;

  // power-up sequencer states, gray along the usual path
  typedef enum logic [2:0] {
    FCS_ST_HOLD   = 3'b000,
    FCS_ST_WAITPU = 3'b001,
    FCS_ST_WAITCK = 3'b011,
    FCS_ST_RUN    = 3'b010,
    FCS_ST_FAIL   = 3'b110
  } fcs_state_t;

  // oscillator status inputs travel together
  typedef struct packed {
    logic osc_edge;      // one-cycle pulse per system oscillator edge
    logic low_power_rc_osc_edge;     // one-cycle pulse per low-power rc edge
    logic ost_done;      // start-up timer expired
    logic pll_locked;
    logic pll_used;
    logic crystal;
  } fcs_osc_status_t;

  // fuse-style configuration
  typedef struct packed {
    logic [1:0] monitor_switch_config;
    logic [1:0] startup_osc_group;
    logic [3:0] primary_osc_select;
    logic       power_up_timer_enable;
  } fcs_config_t;

endpackage
